/* verilog/dpm_sequencer.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - current 33 ms, voltage 16 ms conversions
// - 8-bit mode divides conversion time by sixteen
// - continuous scan round-robins selected voltage inputs
// - status bit set on result: current pair, voltage, power
// - four open-drain pins; pin3 ready, pin4 alert
// - ready shows new data; alert shows faults
// - running minimum and maximum per measurement
// - out-of-window value logs fault, optional alert
// - two three-level pins give nine addresses
// - default: offset first, then load current
// - default voltage order: senses, then gpio1-4
// - latch voltage operand, add per modulator one
// - end of conversion stores power and operand
// - totals summed with least bit dropped
// - calibration captures no current; default every time
// - calibration bit write gives one calibration
// - six inputs refreshed at ten hertz
// - two sense inputs refreshed at thirty hertz
// - snapshot measures one input or a pair
// - snapshot done halts all converters
// - power voltage from senses or gpio1/2
// - mode 00 scan, 01 snapshot, 10 single
// - single cycle converts six inputs once
// - scan field picks inputs; default all six
// - calibration bit zero calibrates every conversion
// - shutdown register bit stops all conversion
module dpm_sequencer #(
  parameter int I_CYC = dpm_pkg::I_CONV_CYC,
  parameter int V_CYC = dpm_pkg::V_CONV_CYC
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  input  wire dpm_pkg::dpm_conv_rsp_t conv_rsp_i,
  output dpm_pkg::dpm_conv_req_t      conv_req_o,
  input  wire logic [1:0]             address_select_high_i,
  input  wire logic [1:0]             address_select_low_i,
  output logic      [6:0]             dev_addr_o,
  input  wire logic [3:0]             gpio_in_i,
  output logic      [3:0]             gpio_o,
  output logic      [3:0]             gpio_oe_o
);
  import dpm_pkg::*;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic [7:0]        cfg;
    logic [3:0]        gpo;
    logic [7:0]        alert_en;
    logic [2:0]        status;
    logic [7:0]        fault;
    logic              boot;
    dpm_ist_t          ist;
    dpm_vst_t          vst;
    logic [22:0]       icnt;
    logic [22:0]       vcnt;
    logic [2:0]        ch;
    logic              pwr_on;
    logic [11:0]       op1;
    logic [11:0]       op2;
    logic [31:0]       acc1;
    logic [31:0]       acc2;
    logic [31:0]       pw1;
    logic [31:0]       pw2;
    logic [11:0]       pv1;
    logic [11:0]       pv2;
    logic [7:0][11:0]  res;
    logic [7:0][11:0]  mn;
    logic [7:0][11:0]  mx;
    logic [7:0][11:0]  lo;
    logic [7:0][11:0]  hi;
    logic [31:0]       rdata;
    logic              i_start;
    logic              v_start;
    logic [6:0]        devaddr;
  } dpm_state_t;

  dpm_state_t s_r;
  dpm_state_t s_nxt;

  // ---------------------------------------------------------------------------
  // Derived control
  // ---------------------------------------------------------------------------
  logic [1:0]  mode;
  logic [2:0]  first_ch;
  logic [2:0]  last_ch;
  logic [22:0] i_per;
  logic [22:0] v_per;
  logic        use_gpio_op;
  logic [11:0] itot;
  logic [31:0] ptot;
  logic [12:0] isum;
  logic [32:0] psum;

  assign mode = s_r.ctrl[CTRL_MODE_LSB +: 2];

  // Eight-bit mode runs sixteen times faster; the shift keeps one constant per period.
  assign i_per = s_r.cfg[CFG_RES8_BIT] ? 23'(I_CYC >> RES8_SHIFT) : 23'(I_CYC);
  assign v_per = s_r.cfg[CFG_RES8_BIT] ? 23'(V_CYC >> RES8_SHIFT) : 23'(V_CYC);

  // Channel window of the voltage list; every list is a contiguous run of channels.
  always_comb begin
    first_ch = CH_S1;
    last_ch  = CH_G4;
    if (mode == MODE_SNAP) begin
      if (s_r.ctrl[2:0] == SNAP_SENSE_PAIR) begin
        first_ch = CH_S1;
        last_ch  = CH_S2;
      end else if (s_r.ctrl[2:0] == SNAP_GPIO_PAIR) begin
        first_ch = CH_G1;
        last_ch  = CH_G2;
      end else begin
        first_ch = s_r.ctrl[2:0];
        last_ch  = s_r.ctrl[2:0];
      end
    end else if (mode == MODE_CONT) begin
      case (s_r.ctrl[CTRL_SCAN_LSB +: 2])
        2'h1: begin
          first_ch = CH_S1;
          last_ch  = CH_S2;
        end
        2'h2: begin
          first_ch = CH_G1;
          last_ch  = CH_G2;
        end
        2'h3: begin
          first_ch = CH_G1;
          last_ch  = CH_G4;
        end
        default: begin
          first_ch = CH_S1;
          last_ch  = CH_G4;
        end
      endcase
    end
  end

  // Power operands come from the gpio pair when chosen or when the scan skips the senses.
  assign use_gpio_op = s_r.cfg[CFG_PSEL_BIT] ||
                       (mode == MODE_CONT && s_r.ctrl[CTRL_SCAN_LSB + 1]);

  // Totals drop the low bit so the sum fits the field width.
  assign isum = {1'b0, s_r.res[0]} + {1'b0, s_r.res[1]};
  assign psum = {1'b0, s_r.pw1} + {1'b0, s_r.pw2};
  assign itot = isum[12:1];
  assign ptot = psum[32:1];

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [7:0]       wr_en;
    logic [7:0][11:0] wr_dat;
    logic             begin_meas;
    logic             go;
    logic [2:0]       st_set;
    logic [2:0]       st_clr;
    logic [7:0]       f_set;
    logic [7:0]       f_clr;
    logic [7:0]       idx;
    logic             restart;
    logic             nv;
    logic [2:0]       vi;
    logic [31:0]      a1;
    logic [31:0]      a2;
    wr_en      = 8'h00;
    wr_dat     = '0;
    begin_meas = 1'b0;
    go         = 1'b0;
    st_set     = 3'h0;
    st_clr     = 3'h0;
    f_set      = 8'h00;
    f_clr      = 8'h00;
    idx        = 8'h00;
    restart    = 1'b0;
    nv         = 1'b0;
    vi         = s_r.ch + 3'h2;
    a1         = 32'h0;
    a2         = 32'h0;
    s_nxt         = s_r;
    s_nxt.i_start = 1'b0;
    s_nxt.v_start = 1'b0;
    s_nxt.devaddr = DEV_ADDR_BASE + 7'(address_select_high_i) * 7'h03
                    + 7'(address_select_low_i);

    // Register writes; a control write restarts the whole sequence.
    if (reg_wr_i) begin
      if (reg_addr_i == ADR_CTRL) begin
        s_nxt.ctrl = reg_wdata_i[7:0];
        restart    = 1'b1;
      end else if (reg_addr_i == ADR_CFG) begin
        s_nxt.cfg = reg_wdata_i[7:0];
      end else if (reg_addr_i == ADR_FAULT) begin
        f_clr = reg_wdata_i[7:0];
      end else if (reg_addr_i == ADR_ALERT_EN) begin
        s_nxt.alert_en = reg_wdata_i[7:0];
      end else if (reg_addr_i == ADR_GPIO) begin
        s_nxt.gpo = reg_wdata_i[3:0];
      end else if (reg_addr_i >= ADR_MIN && reg_addr_i < ADR_MAX) begin
        idx = reg_addr_i - ADR_MIN;
        s_nxt.mn[idx[2:0]] = reg_wdata_i[11:0];
      end else if (reg_addr_i >= ADR_MAX && reg_addr_i < ADR_THR_LO) begin
        idx = reg_addr_i - ADR_MAX;
        s_nxt.mx[idx[2:0]] = reg_wdata_i[11:0];
      end else if (reg_addr_i >= ADR_THR_LO && reg_addr_i < ADR_THR_HI) begin
        idx = reg_addr_i - ADR_THR_LO;
        s_nxt.lo[idx[2:0]] = reg_wdata_i[11:0];
      end else if (reg_addr_i >= ADR_THR_HI && reg_addr_i < ADR_END) begin
        idx = reg_addr_i - ADR_THR_HI;
        s_nxt.hi[idx[2:0]] = reg_wdata_i[11:0];
      end
    end

    // Reading status acknowledges the data-ready indication.
    if (reg_rd_i && reg_addr_i == ADR_STATUS) begin
      st_clr = s_r.status;
    end

    // Power-up and leaving shutdown both start a fresh sequence.
    // A start waits out a pending start pulse so that starts never run back to back.
    if (s_r.boot && !s_r.i_start && !s_r.v_start) begin
      go = 1'b1;
    end

    if (s_r.cfg[CFG_SHDN_BIT]) begin
      s_nxt.ist  = I_IDLE;
      s_nxt.vst  = V_IDLE;
      s_nxt.boot = 1'b1;
    end else if (go) begin
      // Every start calibrates first, which also gives the one-off calibration.
      s_nxt.boot    = 1'b0;
      s_nxt.ist     = I_CAL;
      s_nxt.icnt    = i_per - 23'h1;
      s_nxt.i_start = 1'b1;
      s_nxt.vst     = V_RUN;
      s_nxt.ch      = first_ch;
      s_nxt.vcnt    = v_per - 23'h1;
      s_nxt.v_start = 1'b1;
      s_nxt.pwr_on  = !(mode == MODE_SNAP && s_r.ctrl[2:0] < SNAP_SENSE_PAIR);
    end else begin
      // Both current converters share one sequencer so they stay in lockstep.
      case (s_r.ist)
        I_CAL: begin
          if (s_r.icnt == 23'h0) begin
            begin_meas = 1'b1;
          end else begin
            s_nxt.icnt = s_r.icnt - 23'h1;
          end
        end
        I_MEAS: begin
          // Every modulator one adds the latched voltage, the end cycle included.
          if (conv_rsp_i.mod_valid && conv_rsp_i.current_modulator_one) begin
            a1 = 32'(s_r.op1);
          end
          if (conv_rsp_i.mod_valid && conv_rsp_i.imod2) begin
            a2 = 32'(s_r.op2);
          end
          s_nxt.acc1 = s_r.acc1 + a1;
          s_nxt.acc2 = s_r.acc2 + a2;
          if (s_r.icnt == 23'h0) begin
            // Both currents land together, so they share one status bit.
            wr_en[1:0] = 2'h3;
            wr_dat[0]  = conv_rsp_i.i1_code;
            wr_dat[1]  = conv_rsp_i.i2_code;
            st_set[0]  = 1'b1;
            if (s_r.pwr_on) begin
              s_nxt.pw1 = s_r.acc1 + a1;
              s_nxt.pw2 = s_r.acc2 + a2;
              s_nxt.pv1 = s_r.op1;
              s_nxt.pv2 = s_r.op2;
              st_set[2] = 1'b1;
            end
            if (mode != MODE_CONT) begin
              s_nxt.ist = I_IDLE;
            end else if (s_r.ctrl[CTRL_CAL_BIT]) begin
              begin_meas = 1'b1;
            end else begin
              s_nxt.ist     = I_CAL;
              s_nxt.icnt    = i_per - 23'h1;
              s_nxt.i_start = 1'b1;
            end
          end else begin
            s_nxt.icnt = s_r.icnt - 23'h1;
          end
        end
        default: begin
        end
      endcase
      // A load measurement latches the newest voltages as its power operands.
      if (begin_meas) begin
        s_nxt.ist     = I_MEAS;
        s_nxt.icnt    = i_per - 23'h1;
        s_nxt.i_start = 1'b1;
        s_nxt.acc1    = 32'h0;
        s_nxt.acc2    = 32'h0;
        s_nxt.op1 = use_gpio_op ? s_r.res[CH_G1 + 3'h2]
                                : s_r.res[CH_S1 + 3'h2];
        s_nxt.op2 = use_gpio_op ? s_r.res[CH_G2 + 3'h2]
                                : s_r.res[CH_S2 + 3'h2];
      end
      // The voltage converter stores its code, then steps through the channel window.
      if (s_r.vst == V_RUN) begin
        if (s_r.vcnt == 23'h0) begin
          wr_en[vi]  = 1'b1;
          wr_dat[vi] = conv_rsp_i.v_code;
          st_set[1]  = 1'b1;
          if (s_r.ch != last_ch) begin
            s_nxt.ch = s_r.ch + 3'h1;
            nv       = 1'b1;
          end else if (mode == MODE_CONT) begin
            s_nxt.ch = first_ch;
            nv       = 1'b1;
          end else begin
            s_nxt.vst = V_IDLE;
          end
        end else begin
          s_nxt.vcnt = s_r.vcnt - 23'h1;
        end
      end
      if (nv) begin
        s_nxt.v_start = 1'b1;
        s_nxt.vcnt    = v_per - 23'h1;
      end
    end

    // Results go through one place that also tracks extremes and the window.
    for (int i = 0; i < 8; i++) begin
      if (wr_en[i]) begin
        s_nxt.res[i] = wr_dat[i];
        if (wr_dat[i] < s_r.mn[i]) s_nxt.mn[i] = wr_dat[i];
        if (wr_dat[i] > s_r.mx[i]) s_nxt.mx[i] = wr_dat[i];
        if (wr_dat[i] < s_r.lo[i] || wr_dat[i] > s_r.hi[i]) f_set[i] = 1'b1;
      end
    end

    // A hardware set wins over a clear in the same cycle, so no event is lost.
    s_nxt.status = (s_r.status & ~st_clr) | st_set;
    s_nxt.fault  = (s_r.fault & ~f_clr) | f_set;

    // A control write stops every converter; the new settings start next cycle.
    if (restart) begin
      s_nxt.ist     = I_IDLE;
      s_nxt.vst     = V_IDLE;
      s_nxt.i_start = 1'b0;
      s_nxt.v_start = 1'b0;
      s_nxt.boot    = 1'b1;
    end

    // Read data are registered and stand in the one cycle after the strobe.
    s_nxt.rdata = 32'h0;
    if (reg_rd_i) begin
      if (reg_addr_i == ADR_CTRL) s_nxt.rdata = 32'(s_r.ctrl);
      else if (reg_addr_i == ADR_CFG) s_nxt.rdata = 32'(s_r.cfg);
      else if (reg_addr_i == ADR_STATUS) s_nxt.rdata = 32'(s_r.status);
      else if (reg_addr_i == ADR_FAULT) s_nxt.rdata = 32'(s_r.fault);
      else if (reg_addr_i == ADR_ALERT_EN) s_nxt.rdata = 32'(s_r.alert_en);
      else if (reg_addr_i == ADR_GPIO) s_nxt.rdata = 32'({gpio_in_i, s_r.gpo});
      else if (reg_addr_i == ADR_DEVADDR) s_nxt.rdata = 32'(s_r.devaddr);
      else if (reg_addr_i == ADR_PWR1) s_nxt.rdata = s_r.pw1;
      else if (reg_addr_i == ADR_PWR2) s_nxt.rdata = s_r.pw2;
      else if (reg_addr_i == ADR_PVOLT1) s_nxt.rdata = 32'(s_r.pv1);
      else if (reg_addr_i == ADR_PVOLT2) s_nxt.rdata = 32'(s_r.pv2);
      else if (reg_addr_i == ADR_ITOT) s_nxt.rdata = 32'(itot);
      else if (reg_addr_i == ADR_PTOT) s_nxt.rdata = ptot;
      else if (reg_addr_i >= ADR_RES && reg_addr_i < ADR_MIN)
        s_nxt.rdata = 32'(s_r.res[reg_addr_i[2:0]]);
      else if (reg_addr_i >= ADR_MIN && reg_addr_i < ADR_MAX)
        s_nxt.rdata = 32'(s_r.mn[reg_addr_i[2:0]]);
      else if (reg_addr_i >= ADR_MAX && reg_addr_i < ADR_THR_LO)
        s_nxt.rdata = 32'(s_r.mx[reg_addr_i[2:0]]);
      else if (reg_addr_i >= ADR_THR_LO && reg_addr_i < ADR_THR_HI)
        s_nxt.rdata = 32'(s_r.lo[reg_addr_i[2:0]]);
      else if (reg_addr_i >= ADR_THR_HI && reg_addr_i < ADR_END)
        s_nxt.rdata = 32'(s_r.hi[reg_addr_i[2:0]]);
    end
  end

  // ---------------------------------------------------------------------------
  // State register and outputs
  // ---------------------------------------------------------------------------
  // The reset branch loads constants only; boot makes the first cycle start the scan.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r         <= '0;
      s_r.ctrl    <= CTRL_RST;
      s_r.cfg     <= CFG_RST;
      s_r.boot    <= 1'b1;
      s_r.ist     <= I_IDLE;
      s_r.vst     <= V_IDLE;
      s_r.mn      <= {8{MIN_RST}};
      s_r.mx      <= {8{MAX_RST}};
      s_r.lo      <= {8{LO_RST}};
      s_r.hi      <= {8{HI_RST}};
      s_r.devaddr <= DEV_ADDR_BASE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Starts are masked in shutdown so a start decided just before it never escapes.
  assign conv_req_o = '{i_start:  s_r.i_start && !s_r.cfg[CFG_SHDN_BIT],
                        i_cal:    s_r.ist == I_CAL,
                        v_start:  s_r.v_start && !s_r.cfg[CFG_SHDN_BIT],
                        v_chan:   s_r.ch,
                        res8:     s_r.cfg[CFG_RES8_BIT],
                        shutdown: s_r.cfg[CFG_SHDN_BIT]};
  assign reg_rdata_o = s_r.rdata;
  assign dev_addr_o  = s_r.devaddr;

  // Open-drain pins only ever pull low, so the enable alone carries the level.
  assign gpio_o    = 4'h0;
  assign gpio_oe_o = {s_r.cfg[CFG_ALERT_BIT] ? |(s_r.fault & s_r.alert_en) : s_r.gpo[3],
                      s_r.cfg[CFG_RDY_BIT] ? (s_r.status != 3'h0) : s_r.gpo[2],
                      s_r.gpo[1:0]};
endmodule

/* verilog/dpm_pkg.sv */
package dpm_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (word index on the plain register port)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_CFG      = 8'h01;
  localparam logic [7:0] ADR_STATUS   = 8'h02;
  localparam logic [7:0] ADR_FAULT    = 8'h03;
  localparam logic [7:0] ADR_ALERT_EN = 8'h04;
  localparam logic [7:0] ADR_GPIO     = 8'h05;
  localparam logic [7:0] ADR_DEVADDR  = 8'h06;
  localparam logic [7:0] ADR_PWR1     = 8'h08;
  localparam logic [7:0] ADR_PWR2     = 8'h09;
  localparam logic [7:0] ADR_PVOLT1   = 8'h0A;
  localparam logic [7:0] ADR_PVOLT2   = 8'h0B;
  localparam logic [7:0] ADR_ITOT     = 8'h0C;
  localparam logic [7:0] ADR_PTOT     = 8'h0D;
  localparam logic [7:0] ADR_RES      = 8'h10;
  localparam logic [7:0] ADR_MIN      = 8'h18;
  localparam logic [7:0] ADR_MAX      = 8'h20;
  localparam logic [7:0] ADR_THR_LO   = 8'h28;
  localparam logic [7:0] ADR_THR_HI   = 8'h30;
  localparam logic [7:0] ADR_END      = 8'h38;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int CTRL_CAL_BIT   = 7;
  localparam int CTRL_MODE_LSB  = 5;
  localparam int CTRL_SCAN_LSB  = 3;
  localparam int CFG_RES8_BIT   = 0;
  localparam int CFG_PSEL_BIT   = 1;
  localparam int CFG_RDY_BIT    = 2;
  localparam int CFG_ALERT_BIT  = 3;
  localparam int CFG_SHDN_BIT   = 4;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [11:0] MIN_RST  = 12'hFFF;
  localparam logic [11:0] MAX_RST  = 12'h000;
  localparam logic [11:0] LO_RST   = 12'h000;
  localparam logic [11:0] HI_RST   = 12'hFFF;
  localparam logic [6:0]  DEV_ADDR_BASE = 7'h60; // Arbitrary base value.

  // Measurement modes and voltage channels.
  localparam logic [1:0] MODE_CONT   = 2'h0;
  localparam logic [1:0] MODE_SNAP   = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [2:0] CH_S1 = 3'h0;
  localparam logic [2:0] CH_S2 = 3'h1;
  localparam logic [2:0] CH_G1 = 3'h2;
  localparam logic [2:0] CH_G2 = 3'h3;
  localparam logic [2:0] CH_G4 = 3'h5;
  localparam logic [2:0] SNAP_SENSE_PAIR = 3'h6;
  localparam logic [2:0] SNAP_GPIO_PAIR  = 3'h7;
  localparam int RES8_SHIFT = 4;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam longint CLK_HZ    = 125000000;
  localparam longint I_CONV_MS = 33;
  localparam longint V_CONV_MS = 16;
  localparam int I_CONV_CYC = int'((I_CONV_MS * CLK_HZ) / 1000);
  localparam int V_CONV_CYC = int'((V_CONV_MS * CLK_HZ) / 1000);

  typedef enum logic [1:0] {I_IDLE, I_CAL, I_MEAS} dpm_ist_t;
  typedef enum logic       {V_IDLE, V_RUN}         dpm_vst_t;

  // Control travelling to the analog converters.
  typedef struct packed {
    logic       i_start;
    logic       i_cal;
    logic       v_start;
    logic [2:0] v_chan;
    logic       res8;
    logic       shutdown;
  } dpm_conv_req_t;

  // Results and bitstreams coming back from the converters.
  typedef struct packed {
    logic        mod_valid;
    logic        current_modulator_one;
    logic        imod2;
    logic [11:0] i1_code;
    logic [11:0] i2_code;
    logic [11:0] v_code;
  } dpm_conv_rsp_t;

endpackage

/* verification/dpm_sequencer_sva.sv */
`timescale 1ns/10ps
module dpm_sequencer_sva #(
  parameter int I_CYC = 64,
  parameter int V_CYC = 32
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire dpm_pkg::dpm_conv_req_t conv_req_o,
  input  wire logic [1:0]             address_select_high_i,
  input  wire logic [1:0]             address_select_low_i,
  input  wire logic [6:0]             dev_addr_o,
  input  wire logic [3:0]             gpio_o,
  input  wire logic [3:0]             gpio_oe_o
);
  import dpm_pkg::*;
  // ---------------------------------------------------------------------------
  // Properties on the converter requests, pins and address decode
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // A start is a one-cycle event; a held start would restart the converter.
  chk_vstart_pulse: assert property (conv_req_o.v_start |=> !conv_req_o.v_start)
    else $error("voltage start held longer than one cycle");
  chk_istart_pulse: assert property (conv_req_o.i_start |=> !conv_req_o.i_start)
    else $error("current start held longer than one cycle");
  chk_shdn_quiet: assert property (conv_req_o.shutdown |->
    !(conv_req_o.i_start || conv_req_o.v_start))
    else $error("conversion started in shutdown");
  chk_vchan_range: assert property (conv_req_o.v_start |-> conv_req_o.v_chan <= CH_G4)
    else $error("voltage channel outside the six inputs");
  // Open drain: a driven pin may only be pulled low.
  chk_open_drain: assert property ((gpio_oe_o & gpio_o) == 4'h0)
    else $error("general purpose pin driven high");
  chk_addr_stable: assert property (($stable(address_select_high_i) &&
    $stable(address_select_low_i)) [*3] |-> $stable(dev_addr_o))
    else $error("device address moved with steady select pins");
  chk_addr_nine: assert property ((address_select_high_i != 2'h3 &&
    address_select_low_i != 2'h3) |-> ##2 (dev_addr_o >= DEV_ADDR_BASE &&
    dev_addr_o < DEV_ADDR_BASE + 7'h09))
    else $error("device address outside the nine codes");
  chk_res8_follow: assert property ((reg_wr_i && reg_addr_i == ADR_CFG &&
    reg_wdata_i[CFG_RES8_BIT] && !reg_wdata_i[CFG_SHDN_BIT]) |-> ##[1:2] conv_req_o.res8)
    else $error("resolution select not applied");
  chk_snap_start: assert property ((reg_wr_i && reg_addr_i == ADR_CTRL &&
    reg_wdata_i[6:5] == MODE_SNAP && !conv_req_o.shutdown) |-> ##[1:3] conv_req_o.v_start)
    else $error("snapshot did not start the voltage converter");

  cov_last_chan: cover property (conv_req_o.v_start && conv_req_o.v_chan == CH_G4);
  cov_shutdown: cover property ($rose(conv_req_o.shutdown));
  cov_res8_conv: cover property (conv_req_o.res8 && conv_req_o.v_start);
endmodule
bind dpm_sequencer dpm_sequencer_sva #(.I_CYC(I_CYC), .V_CYC(V_CYC)) u_sva (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .conv_req_o(conv_req_o),
  .address_select_high_i(address_select_high_i),
  .address_select_low_i(address_select_low_i), .dev_addr_o(dev_addr_o),
  .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o));

/* verification/dpm_conv_model.sv */
`timescale 1ns/10ps
module dpm_conv_model (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  input  wire dpm_pkg::dpm_conv_req_t conv_req_i,
  output dpm_pkg::dpm_conv_rsp_t      conv_rsp_o
);
  import dpm_pkg::*;
  logic [3:0] phase_r;
  // ---------------------------------------------------------------------------
  // Converter behaviour: voltage code follows the channel, bitstreams never rest
  // ---------------------------------------------------------------------------
  // The voltage code names its channel so that a wrong operand shows in power.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_rsp_o <= '0;
      phase_r    <= 4'h0;
    end else begin
      phase_r              <= phase_r + 4'h1;
      conv_rsp_o.mod_valid <= !conv_req_i.shutdown;
      conv_rsp_o.current_modulator_one     <= phase_r[0];
      conv_rsp_o.imod2     <= phase_r[1] & phase_r[0];
      conv_rsp_o.i1_code   <= 12'h123;
      conv_rsp_o.i2_code   <= 12'h045;
      if (conv_req_i.v_start) begin
        conv_rsp_o.v_code <= {9'h000, conv_req_i.v_chan} + 12'h200;
      end
    end
  end
endmodule

/* verification/tb.sv */
`timescale 1ns/10ps
module tb;
  import dpm_pkg::*;
  localparam int VC = 32;
  logic core_clk_i, rst_b_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rv;
  logic [1:0] adr_hi, adr_lo;
  logic [6:0] dev_addr_o;
  logic [3:0] gpio_o, gpio_oe_o;
  logic [3:0] gpio_in;
  logic [127:0] seen_addr;
  logic [2:0] ch;
  dpm_conv_req_t req;
  dpm_conv_rsp_t rsp;
  int num_errors, samples_checked, cyc, p12, p8, n;

  dpm_sequencer #(.I_CYC(64), .V_CYC(VC)) u_dut (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .conv_rsp_i(rsp), .conv_req_o(req), .address_select_high_i(adr_hi),
    .address_select_low_i(adr_lo), .dev_addr_o(dev_addr_o), .gpio_in_i(gpio_in),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o));
  dpm_conv_model u_model (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .conv_req_i(req), .conv_rsp_o(rsp));

  // ---------------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // A hung sequencer would never end the run, so cycles are capped.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Waits for the next voltage start under a bound and returns its channel.
  task automatic next_v(output logic [2:0] c, output int gap);
    gap = 0;
    do begin
      @(posedge core_clk_i);
      gap++;
    end while (req.v_start !== 1'b1 && gap < 8 * VC);
    c = req.v_chan;
  endtask
  task automatic run_seq(input logic [7:0] ctrl, input int cnt, input logic [17:0] e);
    wr(ADR_CTRL, {24'h0, ctrl});
    for (int k = 0; k < cnt; k++) begin
      next_v(ch, n);
      chk(ch, e[3*k+:3]);
    end
  endtask
  task automatic quiet();
    n = 0;
    repeat (4 * VC) @(posedge core_clk_i) if (req.v_start === 1'b1) n++;
    chk(n, 0);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0; adr_hi = 2'h0; adr_lo = 2'h0; seen_addr = '0;
    gpio_in = 4'h5;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(ADR_CTRL, rv);   chk(rv, {24'h0, CTRL_RST});
    rd(ADR_CFG, rv);    chk(rv, {24'h0, CFG_RST});
    rd(ADR_MIN, rv);    chk(rv, {20'h0, MIN_RST});
    rd(ADR_MAX, rv);    chk(rv, {20'h0, MAX_RST});
    rd(ADR_THR_LO, rv); chk(rv, {20'h0, LO_RST});
    rd(ADR_THR_HI, rv); chk(rv, {20'h0, HI_RST});
    rd(ADR_END, rv);    chk(rv, 32'h0);
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        @(posedge core_clk_i);
        adr_hi <= h[1:0]; adr_lo <= l[1:0];
        repeat (3) @(posedge core_clk_i);
        seen_addr[dev_addr_o] = 1'b1;
      end
    end
    chk($countones(seen_addr), 9);
    // Default scan: senses first, then the four pins, then round again.
    for (int k = 0; k < 7; k++) begin
      next_v(ch, n);
      if (k == 0) while (ch !== CH_S1 && n < 8 * VC) next_v(ch, n);
      chk(ch, (k % 6));
    end
    run_seq(8'h26, 2, {12'h0, CH_S2, CH_S1});
    quiet();
    run_seq(8'h40, 6, {CH_G4, 3'h4, CH_G2, CH_G1, CH_S2, CH_S1});
    quiet();
    // One 64-cycle measurement: 32 ones of 0x200 and 16 ones of 0x201.
    rd(ADR_ITOT, rv);   chk(rv, 32'hB4);
    rd(ADR_PTOT, rv);   chk(rv, 32'h3008);
    rd(ADR_PVOLT1, rv); chk(rv, 32'h200);
    rd(ADR_STATUS, rv); chk(rv, 32'h7);
    rd(ADR_STATUS, rv); chk(rv, 32'h0);
    wr(ADR_GPIO, 32'h3);
    rd(ADR_GPIO, rv);   chk(rv, 32'h53);
    chk({gpio_o, gpio_oe_o}, 8'h03);
    run_seq(8'h08, 4, {6'h0, CH_S2, CH_S1, CH_S2, CH_S1});
    rd(ADR_CTRL, rv); chk(rv[7:0], 8'h08);
    next_v(ch, p12);
    next_v(ch, p12);
    wr(ADR_CFG, 32'h1);
    next_v(ch, p8);
    next_v(ch, p8);
    chk(req.res8, 1'b1);
    chk(p8 < p12, 1'b1);
    chk(p12 >= VC, 1'b1);
    wr(ADR_CFG, 32'h10);
    quiet();
    test_done();
  end
endmodule
